// ==== logic/scp_pkg.sv ====
package scp_pkg;
   // data path sizes
   localparam int ADDR_W     = 6;
   localparam int DATA_W     = 8;
   localparam int NUM_REGS   = 64;
   localparam int SD_W       = 12;
   localparam int CNT_W      = 5;
   localparam int SYNC_W     = 3;

   // bit counts along a transfer, in rising link-clock edges
   localparam logic [CNT_W-1:0] HDR_LAST  = 5'h07;
   localparam logic [CNT_W-1:0] BYTE1_LAST = 5'h0F;
   localparam logic [CNT_W-1:0] BYTE2_LAST = 5'h17;

   // header field positions (natural order after assembly)
   localparam int HDR_RNW_BIT = 7;
   localparam int HDR_TWO_BIT = 6;

   // register offsets
   localparam logic [ADDR_W-1:0] PORT_CFG_ADDR   = 6'h00;
   localparam logic [ADDR_W-1:0] AUX_DAC_A_ADDR  = 6'h24;
   localparam logic [ADDR_W-1:0] AUX_DAC_B_ADDR  = 6'h25;
   localparam logic [ADDR_W-1:0] AUX_DAC_C_ADDR  = 6'h26;
   localparam logic [ADDR_W-1:0] AUX_DAC_CTL_ADDR = 6'h29;
   localparam logic [ADDR_W-1:0] SD_HIGH_ADDR    = 6'h2A;
   localparam logic [ADDR_W-1:0] SD_LOW_ADDR     = 6'h2B;
   localparam logic [ADDR_W-1:0] RX_BIAS_A_ADDR  = 6'h31;
   localparam logic [ADDR_W-1:0] RX_BIAS_B_ADDR  = 6'h32;
   localparam logic [ADDR_W-1:0] REVISION_ADDR   = 6'h3F;

   // field positions
   localparam int CFG_THREE_WIRE_BIT = 7;
   localparam int CFG_LOW_ORDER_BIT  = 6;
   localparam int INV_C_BIT          = 4;
   localparam int INV_B_BIT          = 2;
   localparam int INV_A_BIT          = 0;
   localparam int SD_LOW_LSB         = 4;

   // values after reset
   localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
   localparam logic [SD_W:0]     SD_ACC_RESET = 13'h0000;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_RESET  = 5'h00;

   // link limits and local clock, for reference by the bench
   localparam int MCLK_HZ      = 50_000_000;
   localparam int LINK_MAX_HZ  = 16_000_000;

   // transfer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_HEAD  = 5'b00010,
      ST_WRITE = 5'b00100,
      ST_READ  = 5'b01000,
      ST_DONE  = 5'b10000
   } xfer_state_t;
endpackage

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 3
) (
   // clock and control
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             ce,
   // asynchronous levels in, local levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // two stages; only the second stage reads the first
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ==== logic/serial_control_port.sv ====
`timescale 1ns/1ps
// What this block does
// - header is rnw, two-byte flag, 6-bit address
// - select low gates cycles, else pins released
// - sample on rising, drive on falling edge
// - commit after 16th or 24th rising edge
// - early deselect discards the write entirely
// - data pin input-only unless three-wire set
// - four-wire reads return on dedicated output
// - two-byte flag picks one or two bytes on writes
// - low bit order reverses header and data
// - msb-first second byte goes to N-1
// - lsb-first second byte goes to N+1
// - reads return exactly one byte always
// - three-wire read turns data pin outward
// - 12-bit sigma-delta word, zero at reset
// - invert bits 4,2,0 flip aux words
// - revision register read-only, writes ignored
// - aux words 8-bit straight binary, reset zero
module serial_control_port #(
   parameter logic [7:0] REVISION = 8'h01  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          ce,
   // serial link pins
   input  wire logic                          port_select_n,
   input  wire logic                          shift_clock,
   input  wire logic                          serial_data_io_i,
   output logic                               serial_data_io_o,
   output logic                               serial_data_io_oe,
   output logic                               serial_data_out_o,
   output logic                               serial_data_out_oe,
   // configured outputs
   output logic [scp_pkg::DATA_W-1:0]         aux_dac_a,
   output logic [scp_pkg::DATA_W-1:0]         aux_dac_b,
   output logic [scp_pkg::DATA_W-1:0]         aux_dac_c,
   output logic [scp_pkg::SD_W-1:0]           sigma_delta_word,
   output logic                               sigma_delta_out,
   output logic [scp_pkg::DATA_W-1:0]         rx_bias_a,
   output logic [scp_pkg::DATA_W-1:0]         rx_bias_b,
   output logic                               three_wire_select,
   output logic                               low_bit_order
);
   import scp_pkg::*;

   logic [SYNC_W-1:0] pins_s;
   logic              sclk_s;
   logic              sdi_s;
   logic              sclk_d_r;
   logic              rise;
   logic              fall;
   logic              sel;
   xfer_state_t       state_r;
   xfer_state_t       state_nxt;
   logic [CNT_W-1:0]  cnt_r;
   logic [DATA_W-1:0] shift_r;
   logic [DATA_W-1:0] shift_nxt;
   logic [DATA_W-1:0] first_r;
   logic              two_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] out_sh_r;
   logic [DATA_W-1:0] regs_r [NUM_REGS];
   logic              hdr_done;
   logic              byte1_done;
   logic              byte2_done;
   logic              commit_one;
   logic              commit_two;
   logic [ADDR_W-1:0] addr_second;
   logic [SD_W:0]     sd_acc_r;
   logic [SD_W:0]     sd_sum;
   logic              in_read;

   // assemble one bit into a byte; result is always in natural order
   // so the header fields sit at fixed positions in either bit order
   function automatic logic [DATA_W-1:0] shift_in(
      input logic [DATA_W-1:0] sh,
      input logic              b,
      input logic              lsb_first
   );
      if (lsb_first)
         shift_in = {b, sh[DATA_W-1:1]};
      else
         shift_in = {sh[DATA_W-2:0], b};
   endfunction

   // readback mux; revision is a constant, not a flop,
   // and a write to it has nowhere to land
   function automatic logic [DATA_W-1:0] reg_value(
      input logic [ADDR_W-1:0] a
   );
      if (a == REVISION_ADDR)
         reg_value = REVISION;
      else
         reg_value = regs_r[a];
   endfunction

   // an aux word, optionally inverted
   function automatic logic [DATA_W-1:0] aux_word(
      input logic [DATA_W-1:0] w,
      input logic              inv
   );
      aux_word = inv ? ~w : w;
   endfunction

   // only the revision code refuses writes; all else is plain storage
   function automatic logic writable(
      input logic [ADDR_W-1:0] a
   );
      writable = a != REVISION_ADDR;
   endfunction

   // link pins cross into mclk before anything reads them; select
   // crosses inverted so the cleared synchroniser reads as idle,
   // otherwise every reset would look like a short select
   pin_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .mclk    (mclk),
      .resetn  (resetn),
      .ce      (ce),
      .async_in({shift_clock, ~port_select_n, serial_data_io_i}),
      .sync_out(pins_s)
   );

   assign sclk_s  = pins_s[2];
   assign sel     = pins_s[1];
   assign sdi_s   = pins_s[0];

   // mode bits live in the port configuration register
   assign three_wire_select = regs_r[PORT_CFG_ADDR][CFG_THREE_WIRE_BIT];
   assign low_bit_order     = regs_r[PORT_CFG_ADDR][CFG_LOW_ORDER_BIT];

   // link clock edge detect on the synchronised copy
   // reset value matches the idle-low link clock, so no false edge
   always_ff @(posedge mclk) begin
      if (!resetn)
         sclk_d_r <= 1'b0;
      else if (ce)
         sclk_d_r <= sclk_s;
   end

   // an edge is seen two to three mclk after the pin moves, so each
   // link clock level must last at least three mclk
   assign rise = sel & sclk_s & ~sclk_d_r;
   assign fall = sel & ~sclk_s & sclk_d_r;

   // bit position decode along the transfer
   // a write commits only at its last bit, never earlier
   assign shift_nxt  = shift_in(shift_r, sdi_s, low_bit_order);
   assign hdr_done   = rise && state_r == ST_HEAD && cnt_r == HDR_LAST;
   assign byte1_done = rise && state_r == ST_WRITE && cnt_r == BYTE1_LAST;
   assign byte2_done = rise && state_r == ST_WRITE && cnt_r == BYTE2_LAST;
   assign commit_one = byte1_done && !two_r;
   assign commit_two = byte2_done && two_r;

   // second byte address walks down or up with the bit order
   assign addr_second = low_bit_order ? ADDR_W'(addr_r + 6'h01)
                                      : ADDR_W'(addr_r - 6'h01);

   // transfer sequencing; deselect wins over everything
   // so a cut frame always falls back to idle with nothing stored
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (sel)
               state_nxt = ST_HEAD;
         end
         ST_HEAD: begin
            if (hdr_done)
               state_nxt = shift_nxt[HDR_RNW_BIT] ? ST_READ : ST_WRITE;
         end
         ST_WRITE: begin
            if (commit_one || commit_two)
               state_nxt = ST_DONE;
         end
         ST_READ: begin
            state_nxt = ST_READ;  // held to deselect, one byte only
         end
         ST_DONE: begin
            state_nxt = ST_DONE;  // extra clocks are ignored
         end
      endcase
      if (!sel)
         state_nxt = ST_IDLE;
   end

   // state register
   always_ff @(posedge mclk) begin
      if (!resetn)
         state_r <= ST_IDLE;
      else if (ce)
         state_r <= state_nxt;
   end

   // rising-edge counter, cleared whenever the port is idle
   // it stops at BYTE2_LAST, the 24th edge, so extra clocks cannot wrap around
   always_ff @(posedge mclk) begin
      if (!resetn)
         cnt_r <= CNT_RESET;
      else if (ce) begin
         if (state_r == ST_IDLE || !sel)
            cnt_r <= CNT_RESET;
         else if (rise && cnt_r != BYTE2_LAST)
            cnt_r <= CNT_W'(cnt_r + 5'h01);
      end
   end

   // input shifter, moved only on sampled rising edges
   always_ff @(posedge mclk) begin
      if (!resetn)
         shift_r <= REG_RESET;
      else if (ce && rise && (state_r == ST_HEAD || state_r == ST_WRITE))
         shift_r <= shift_nxt;
   end

   // header fields, taken at the eighth rising edge
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         two_r  <= 1'b0;
         addr_r <= '0;
      end else if (ce && hdr_done) begin
         two_r  <= shift_nxt[HDR_TWO_BIT];
         addr_r <= shift_nxt[ADDR_W-1:0];
      end
   end

   // first data byte, held for a two-byte commit
   always_ff @(posedge mclk) begin
      if (!resetn)
         first_r <= REG_RESET;
      else if (ce && byte1_done)
         first_r <= shift_nxt;
   end

   // register file; writes only land at a full commit, so a
   // truncated frame leaves every register untouched; the
   // revision code has no flop here at all
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_REGS; i++)
            regs_r[i] <= REG_RESET;
      end else if (ce) begin
         if (commit_one && writable(addr_r))
            regs_r[addr_r] <= shift_nxt;
         if (commit_two) begin
            if (writable(addr_r))
               regs_r[addr_r] <= first_r;
            if (writable(addr_second))
               regs_r[addr_second] <= shift_nxt;
         end
      end
   end

   // read shifter: loaded after the header, moved on falling edges
   always_ff @(posedge mclk) begin
      if (!resetn)
         out_sh_r <= REG_RESET;
      else if (ce) begin
         if (hdr_done)
            out_sh_r <= reg_value(shift_nxt[ADDR_W-1:0]);
         else if (fall && in_read)
            out_sh_r <= low_bit_order ? {1'b0, out_sh_r[DATA_W-1:1]}
                                      : {out_sh_r[DATA_W-2:0], 1'b0};
      end
   end

   // output bit moves only on a falling edge, so the host's
   // rising-edge sample always meets a settled level
   always_ff @(posedge mclk) begin
      if (!resetn)
         serial_data_io_o <= 1'b0;
      else if (ce && fall && in_read)
         serial_data_io_o <= low_bit_order ? out_sh_r[0]
                                           : out_sh_r[DATA_W-1];
   end

   // both outputs share one data flop; only one is ever enabled
   assign serial_data_out_o = serial_data_io_o;

   // a read holds from its header to deselect, one byte then idle bits
   assign in_read = state_r == ST_READ;

   // direction control; enables drop once the synchronised select shows deselect
   assign serial_data_io_oe  = sel && in_read
                               && three_wire_select;
   assign serial_data_out_oe = sel && in_read
                               && !three_wire_select;

   // aux words, taken the cycle after a commit; the invert bits act
   // on whatever word is stored, so order of writes does not matter
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         aux_dac_a <= REG_RESET;
         aux_dac_b <= REG_RESET;
         aux_dac_c <= REG_RESET;
      end else if (ce) begin
         aux_dac_a <= aux_word(regs_r[AUX_DAC_A_ADDR],
                         regs_r[AUX_DAC_CTL_ADDR][INV_A_BIT]);
         aux_dac_b <= aux_word(regs_r[AUX_DAC_B_ADDR],
                         regs_r[AUX_DAC_CTL_ADDR][INV_B_BIT]);
         aux_dac_c <= aux_word(regs_r[AUX_DAC_C_ADDR],
                         regs_r[AUX_DAC_CTL_ADDR][INV_C_BIT]);
      end
   end

   // sigma-delta word; high byte and top nibble of the low byte
   always_ff @(posedge mclk) begin
      if (!resetn)
         sigma_delta_word <= '0;
      else if (ce)
         sigma_delta_word <= {regs_r[SD_HIGH_ADDR],
                              regs_r[SD_LOW_ADDR][DATA_W-1:SD_LOW_LSB]};
   end

   // receive bias settings, plain copies of their registers
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rx_bias_a <= REG_RESET;
         rx_bias_b <= REG_RESET;
      end else if (ce) begin
         rx_bias_a <= regs_r[RX_BIAS_A_ADDR];
         rx_bias_b <= regs_r[RX_BIAS_B_ADDR];
      end
   end

   // first-order modulator: density of ones tracks the word,
   // so a larger word integrates to a higher level
   assign sd_sum = {1'b0, sd_acc_r[SD_W-1:0]}
                   + {1'b0, sigma_delta_word};

   // the carry of each sum is the next output bit
   always_ff @(posedge mclk) begin
      if (!resetn)
         sd_acc_r <= SD_ACC_RESET;
      else if (ce)
         sd_acc_r <= sd_sum;
   end

   assign sigma_delta_out = sd_acc_r[SD_W];
endmodule

// ==== dv/scp_checker_sva.sv ====
`timescale 1ns/1ps
module scp_checker (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   // link side
   input  wire logic                       port_select_n,
   input  wire logic                       serial_data_io_oe,
   input  wire logic                       serial_data_out_oe,
   input  wire logic                       three_wire_select,
   // configured outputs
   input  wire logic [scp_pkg::DATA_W-1:0] aux_dac_a,
   input  wire logic [scp_pkg::DATA_W-1:0] aux_dac_b,
   input  wire logic [scp_pkg::DATA_W-1:0] aux_dac_c,
   input  wire logic [scp_pkg::SD_W-1:0]   sigma_delta_word,
   input  wire logic                       sigma_delta_out,
   input  wire logic [scp_pkg::DATA_W-1:0] rx_bias_a,
   input  wire logic [scp_pkg::DATA_W-1:0] rx_bias_b
);
   import scp_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // deselect must have passed the synchronizer before pins are checked
   chk_idle_pins_off: assert property (
      port_select_n [*5] |-> !serial_data_io_oe && !serial_data_out_oe)
      else $error("data pins driven while deselected");
   chk_io_input_only: assert property (
      !three_wire_select |-> !serial_data_io_oe)
      else $error("data pin driven in four-wire mode");
   chk_out_off_3w: assert property (
      three_wire_select |-> !serial_data_out_oe)
      else $error("dedicated output driven in three-wire mode");
   chk_out_read_start: assert property (
      $rose(serial_data_out_oe) |-> !three_wire_select && !port_select_n)
      else $error("dedicated output enabled outside a read");
   chk_io_turn_out: assert property (
      $rose(serial_data_io_oe) |-> three_wire_select && !port_select_n)
      else $error("data pin turned outward outside a read");
   // outputs move only from a committed write, which lands before deselect
   chk_sd_write_only: assert property (
      $changed(sigma_delta_word) |-> !port_select_n)
      else $error("sigma-delta word changed without a write");
   chk_aux_write_only: assert property (
      $changed({aux_dac_a, aux_dac_b, aux_dac_c}) |-> !port_select_n)
      else $error("aux word changed without a write");
   chk_bias_write_only: assert property (
      $changed({rx_bias_a, rx_bias_b}) |-> !port_select_n)
      else $error("bias setting changed without a write");
   chk_sd_zero_quiet: assert property (
      (sigma_delta_word == 12'h000) [*3] |-> !sigma_delta_out)
      else $error("modulator pulses with a zero word");

   cov_three_wire_read: cover property ($rose(serial_data_io_oe));
   cov_four_wire_read: cover property ($rose(serial_data_out_oe));
   cov_sd_update: cover property ($changed(sigma_delta_word));
endmodule

bind serial_control_port scp_checker u_chk (
   .mclk(mclk), .resetn(resetn), .port_select_n(port_select_n),
   .serial_data_io_oe(serial_data_io_oe),
   .serial_data_out_oe(serial_data_out_oe),
   .three_wire_select(three_wire_select), .aux_dac_a(aux_dac_a),
   .aux_dac_b(aux_dac_b), .aux_dac_c(aux_dac_c),
   .sigma_delta_word(sigma_delta_word), .sigma_delta_out(sigma_delta_out),
   .rx_bias_a(rx_bias_a), .rx_bias_b(rx_bias_b));

// ==== dv/scp_host.sv ====
`timescale 1ns/1ps
module scp_host (
   // clock
   input  wire logic mclk,
   // link pins toward the device
   output logic      port_select_n,
   output logic      shift_clock,
   output logic      host_data,
   // lines as seen by the host
   input  wire logic io_wire,
   input  wire logic out_wire
);
   initial begin
      port_select_n = 1'b1;
      shift_clock   = 1'b0;
      host_data     = 1'b0;
   end

   // one framed transfer; clock idles low and stands still between frames
   task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd,
                       input int nbits, input logic lsb, input logic three,
                       output logic [7:0] rd);
      int i;
      logic b;
      rd = 8'h00;
      @(posedge mclk) port_select_n <= 1'b0;
      for (i = 0; i < nbits; i++) begin
         if (i < 8)
            b = lsb ? hdr[i] : hdr[7-i];
         else if (lsb)
            b = (i < 16) ? wd[i] : wd[i-16];
         else
            b = wd[23-i];
         // a released line shows a moving pattern, not its last value
         if (i < 8 || !hdr[7])
            host_data <= b;
         else
            host_data <= ~host_data;
         repeat (4) @(posedge mclk);
         shift_clock <= 1'b1; // 8 mclk per bit, 160 ns
         @(posedge mclk);
         b = three ? io_wire : out_wire;
         if (i >= 8 && lsb)
            rd[i-8] = b;
         else if (i >= 8)
            rd[15-i] = b;
         repeat (3) @(posedge mclk);
         shift_clock <= 1'b0;
      end
      repeat (8) @(posedge mclk);
      port_select_n <= 1'b1;
      repeat (5) @(posedge mclk);
   endtask
endmodule

// ==== dv/serial_control_port_tb.sv ====
`timescale 1ns/1ps
module serial_control_port_tb;
   import scp_pkg::*;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } row_t;
   localparam logic [7:0] REV   = 8'h5C;  // arbitrary value
   localparam int         LIMIT = 20000;
   logic        mclk   = 1'b0;
   logic        resetn = 1'b0;
   logic        ce     = 1'b1;
   wire logic   sel_n, sclk, host_d, io_wire, out_wire;
   logic        io_o, io_oe, out_o, out_oe, sd_out, three_w, low_ord;
   logic [7:0]  aux_a, aux_b, aux_c, bias_a, bias_b, rd;
   logic [11:0] sd_word;
   logic [11:0] ones;
   int          num_errors   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   // plain register traffic, written then read back on four wires
   row_t rows [0:7] = '{'{8'h24, 8'h5A, 8'h5A}, '{8'h25, 8'h00, 8'h00},
      '{8'h26, 8'hFF, 8'hFF}, '{8'h2A, 8'hAB, 8'hAB}, '{8'h2B, 8'hC0, 8'hC0},
      '{8'h31, 8'h03, 8'h03}, '{8'h32, 8'hEC, 8'hEC}, '{8'h3F, 8'h77, REV}};

   always #10 mclk = ~mclk;
   // shared data pin resolved from both ends; dedicated output reads inverted when released
   assign io_wire  = io_oe ? io_o : host_d;
   assign out_wire = out_oe ? out_o : ~out_o;

   serial_control_port #(.REVISION(REV)) dut (
      .mclk(mclk), .resetn(resetn), .ce(ce), .port_select_n(sel_n),
      .shift_clock(sclk), .serial_data_io_i(io_wire),
      .serial_data_io_o(io_o), .serial_data_io_oe(io_oe),
      .serial_data_out_o(out_o), .serial_data_out_oe(out_oe),
      .aux_dac_a(aux_a), .aux_dac_b(aux_b), .aux_dac_c(aux_c),
      .sigma_delta_word(sd_word), .sigma_delta_out(sd_out),
      .rx_bias_a(bias_a), .rx_bias_b(bias_b),
      .three_wire_select(three_w), .low_bit_order(low_ord));
   scp_host host (.mclk(mclk), .port_select_n(sel_n), .shift_clock(sclk),
      .host_data(host_d), .io_wire(io_wire), .out_wire(out_wire));

   task automatic summarize();
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset();
      @(posedge mclk) resetn <= 1'b0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask

   // a hang is cut short and counted as a mismatch
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      do_reset();
      foreach (rows[k]) begin
         host.xfer(rows[k].addr, {rows[k].data, 8'h00}, 16, 1'b0, 1'b0, rd);
         host.xfer(8'h80 | rows[k].addr, 16'h0000, 16, 1'b0, 1'b0, rd);
         check({4'h0, rd}, {4'h0, rows[k].exp});
      end
      host.xfer(8'h10, 16'h0000, 16, 1'b0, 1'b0, rd);
      check(sd_word, 12'hABC);
      // over one full accumulator period the ones count equals the word
      ones = 12'h000;
      repeat (4096) @(negedge mclk) ones = ones + {11'h000, sd_out};
      check(ones, 12'hABC);
      check({4'h0, bias_a}, 12'h003);
      check({4'h0, bias_b}, 12'h0EC);
      check({4'h0, aux_a}, 12'h05A);
      host.xfer(8'h29, 16'h1500, 16, 1'b0, 1'b0, rd);
      check({4'h0, aux_a}, 12'h0A5);
      check({4'h0, aux_b}, 12'h0FF);
      check({4'h0, aux_c}, 12'h000);
      host.xfer(8'h72, 16'h1122, 24, 1'b0, 1'b0, rd);
      check({4'h0, bias_b}, 12'h011);
      check({4'h0, bias_a}, 12'h022);
      // two-byte write cut off after the first data byte
      host.xfer(8'h72, 16'h3344, 16, 1'b0, 1'b0, rd);
      check({4'h0, bias_b}, 12'h011);
      host.xfer(8'h00, 16'h4000, 16, 1'b0, 1'b0, rd);
      check({11'h000, low_ord}, 12'h001);
      host.xfer(8'h64, 16'h1234, 24, 1'b1, 1'b0, rd);
      check({4'h0, aux_a}, 12'h0ED);
      check({4'h0, aux_b}, 12'h0CB);
      host.xfer(8'hE5, 16'h0000, 16, 1'b1, 1'b0, rd);
      check({4'h0, rd}, 12'h034);
      host.xfer(8'h00, 16'h8000, 16, 1'b1, 1'b0, rd);
      check({10'h000, three_w, low_ord}, 12'h002);
      host.xfer(8'hE6, 16'h0000, 16, 1'b0, 1'b1, rd);
      check({4'h0, rd}, 12'h0FF);
      check({11'h000, io_oe}, 12'h000);
      // a frame sent while the enable is low must leave no trace
      ce <= 1'b0;
      host.xfer(8'h26, 16'h0F00, 16, 1'b0, 1'b1, rd);
      ce <= 1'b1;
      repeat (3) @(posedge mclk);
      check({4'h0, aux_c}, 12'h000);
      // second reset in mid-run clears every setting
      do_reset();
      check({10'h000, three_w, low_ord}, 12'h000);
      check(sd_word, 12'h000);
      check({4'h0, aux_a | aux_b | aux_c}, 12'h000);
      check({4'h0, bias_a | bias_b}, 12'h000);
      host.xfer(8'hBF, 16'h0000, 16, 1'b0, 1'b0, rd);
      check({4'h0, rd}, {4'h0, REV});
      summarize();
   end
endmodule
